/* File: hdl/freq_ref_pkg.sv */
// Package: constants and types for the frequency reference and counter block
`default_nettype none
package freq_ref_pkg;
  // Clock and pulse-rate gate window
  localparam int CLK_FREQ_MHZ = 50;
  localparam int PULSE_GATE_US = 10000;
  localparam int PULSE_GATE_CYC = PULSE_GATE_US * CLK_FREQ_MHZ;
  localparam int GATE_W = 20;
  // Fractions of maximum frequency, 4096 is full scale
  localparam int FRAC_SHIFT = 12;
  localparam logic [12:0] FRAC_FULL = 13'h1000;
  // Terminals
  localparam int N_DI = 5;
  localparam int N_DO = 3;
  localparam int FAST_DI = 4;
  localparam int N_PRESET = 16;
  // Frequency source codes
  localparam logic [3:0] SRC_DIGITAL = 4'h0;
  localparam logic [3:0] SRC_DIGITAL_RET = 4'h1;
  localparam logic [3:0] SRC_ANALOG_FIRST = 4'h2;
  localparam logic [3:0] SRC_ANALOG_SECOND = 4'h3;
  localparam logic [3:0] SRC_PULSE = 4'h5;
  localparam logic [3:0] SRC_MULTI = 4'h6;
  localparam logic [3:0] SRC_PLC = 4'h7;
  localparam logic [3:0] SRC_PID = 4'h8;
  localparam logic [3:0] SRC_COMM = 4'h9;
  // Command sources
  localparam logic [1:0] CMD_PANEL = 2'h0;
  localparam logic [1:0] CMD_TERMINAL = 2'h1;
  localparam logic [1:0] CMD_COMM = 2'h2;
  // Input terminal function codes
  localparam logic [5:0] FN_MS0 = 6'h0c;
  localparam logic [5:0] FN_MS3 = 6'h0f;
  localparam logic [5:0] FN_COUNT_IN = 6'h19;
  localparam logic [5:0] FN_LEN_IN = 6'h1b;
  localparam logic [5:0] FN_LEN_RST = 6'h1c;
  localparam logic [5:0] FN_PID_SWITCH = 6'h2b;
  // Output terminal function codes
  localparam logic [5:0] DO_SET_COUNT = 6'h08;
  localparam logic [5:0] DO_DESIG_COUNT = 6'h09;
  localparam logic [5:0] DO_LEN_REACHED = 6'h14;
  // PID scaling
  localparam int PID_SHIFT = 8;
  localparam int PID_INT_MAX = 8388607;
  // Event counter states
  typedef enum logic [1:0] {
    CNT_RUN = 2'b01,
    CNT_DONE = 2'b10
  } count_state_t;
endpackage
`default_nettype wire

/* File: hdl/freq_reference_and_counters.sv */
// Module: frequency reference selection, direction, length and event counters
// Overview of operation
// - Bound command source uses its own channel
// - Analog full scale maps to maximum frequency
// - Pulse rate mapped by two-point line
// - Two PID units, auto or terminal switch
// - Sixteen presets from terminal functions 12-15
// - Index picks preset times maximum frequency
// - Unassigned index bits read as zero
// - Negative communication frequency commands reverse
// - Reverse inhibited gives zero frequency, no output
// - Direction invert swaps forward and reverse
// - Length equals pulses over pulses per meter
// - Length reached when actual exceeds set
// - Function 28 input clears length
// - Length ignores direction, fast terminal only
// - Set count reached asserts, counting stops
// - Designated count asserts, counting continues
// - Counting independent of run state
// - Event count restorable after power loss
`default_nettype none
module freq_reference_and_counters
  import freq_ref_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = PULSE_GATE_CYC,
  parameter int CNT_W = 32
)(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Terminals
  input wire logic [N_DI-1:0] di_i,
  input wire logic [N_DI-1:0][5:0] di_function_i,
  input wire logic [N_DO-1:0][5:0] do_function_i,
  output logic [N_DO-1:0] do_o,
  // Run commands
  input wire logic run_fwd_i,
  input wire logic run_rev_i,
  // Source selection
  input wire logic [1:0] command_source_select_i,
  input wire logic [11:0] source_binding_select_i,
  input wire logic [3:0] main_source_select_i,
  input wire logic [3:0] aux_source_select_i,
  input wire logic use_aux_i,
  input wire logic [15:0] max_frequency_i,
  input wire logic direction_invert_i,
  input wire logic reverse_inhibit_i,
  // Source values
  input wire logic [12:0] digital_frac_i,
  input wire logic [12:0] plc_frac_i,
  input wire logic signed [13:0] comm_frac_i,
  input wire logic [11:0] analog_input_first_i,
  input wire logic [11:0] analog_input_second_i,
  // Curves
  input wire logic [1:0][2:0] analog_curve_select_i,
  input wire logic [4:0][11:0] curve_in_lo_i,
  input wire logic [4:0][11:0] curve_in_hi_i,
  input wire logic [4:0][12:0] curve_set_lo_i,
  input wire logic [4:0][12:0] curve_set_hi_i,
  input wire logic [15:0] pulse_curve_first_param_i,
  input wire logic [15:0] pulse_curve_in_hi_i,
  input wire logic [12:0] pulse_curve_set_lo_i,
  input wire logic [12:0] pulse_curve_set_hi_i,
  // Preset table
  input wire logic preset_wr_i,
  input wire logic [3:0] preset_addr_i,
  input wire logic [12:0] preset_data_i,
  // PID
  input wire logic [12:0] pid_setpoint_i,
  input wire logic [12:0] pid_feedback_i,
  input wire logic [1:0][7:0] pid_kp_i,
  input wire logic [1:0][7:0] pid_ki_i,
  input wire logic pid_auto_switch_i,
  input wire logic [12:0] pid_switch_error_i,
  // Length
  input wire logic [15:0] pulses_per_meter_i,
  input wire logic [31:0] set_length_i,
  // Event counter
  input wire logic [CNT_W-1:0] set_count_i,
  input wire logic [CNT_W-1:0] designated_count_i,
  input wire logic count_clear_i,
  input wire logic count_load_i,
  input wire logic [CNT_W-1:0] count_load_value_i,
  // Results
  output logic [15:0] target_freq_o,
  output logic drive_enable_o,
  output logic motor_reverse_o,
  output logic pid_unit_o,
  output logic [31:0] actual_length_o,
  output logic length_reached_o,
  output logic [CNT_W-1:0] count_value_o,
  output logic set_count_reached_o,
  output logic designated_count_reached_o
);
  typedef struct packed {
    logic [N_DI-1:0] di_meta;
    logic [N_DI-1:0] di_sync;
    logic [N_DI-1:0] di_prev;
    logic [GATE_W-1:0] gate_cnt;
    logic [15:0] pulse_acc;
    logic [15:0] pulse_rate;
    logic [31:0] length_pulses;
    logic [31:0] actual_length;
    logic length_reached;
    logic [CNT_W-1:0] event_count;
    count_state_t cnt_state;
    logic set_reached;
    logic desig_reached;
    logic signed [23:0] pid_integ;
    logic [12:0] pid_out;
    logic pid_unit;
    logic [15:0] freq;
    logic drive_en;
    logic motor_rev;
  } state_t;

  localparam state_t RESET_ST = '{cnt_state: CNT_RUN, default: '0};

  state_t st;
  state_t next_st;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [12:0] map_curve(input logic [15:0] x, input logic [15:0] xlo,
    input logic [15:0] xhi, input logic [12:0] ylo, input logic [12:0] yhi);
    int dx;
    int dy;
    int y;
    dx = int'(xhi) - int'(xlo);
    dy = int'(yhi) - int'(ylo);
    if (x <= xlo || dx <= 0)
      y = int'(ylo);
    else if (x >= xhi)
      y = int'(yhi);
    else
      y = int'(ylo) + (int'(x) - int'(xlo)) * dy / dx;
    if (y > int'(FRAC_FULL))
      y = int'(FRAC_FULL);
    return y[12:0];
  endfunction

  function automatic logic [15:0] scale_freq(input logic [12:0] frac, input logic [15:0] fmax);
    logic [28:0] prod;
    prod = 29'(frac) * 29'(fmax);
    return prod[27:12];
  endfunction

  // ----------------------------------------------------------------
  // Terminal decoding
  // ----------------------------------------------------------------
  preset_if preset_bus ();
  logic [N_DI-1:0] di_rise;
  logic [3:0] ms_idx;
  logic len_rst;
  logic count_edge;
  logic pid_term;
  logic len_edge;

  assign di_rise = st.di_sync & ~st.di_prev;
  // Only the fast terminal may feed the length count, rising edges only
  assign len_edge = di_rise[FAST_DI] && di_function_i[FAST_DI] == FN_LEN_IN;

  always_comb
  begin
    ms_idx = '0;
    len_rst = 1'b0;
    count_edge = 1'b0;
    pid_term = 1'b0;
    for (int k = 0; k < N_DI; k++)
    begin
      // Bits with no terminal assigned stay zero
      if (di_function_i[k] >= FN_MS0 && di_function_i[k] <= FN_MS3 && st.di_sync[k])
        ms_idx[di_function_i[k][1:0]] = 1'b1;
      if (di_function_i[k] == FN_LEN_RST && st.di_sync[k])
        len_rst = 1'b1;
      if (di_function_i[k] == FN_COUNT_IN && di_rise[k])
        count_edge = 1'b1;
      if (di_function_i[k] == FN_PID_SWITCH && st.di_sync[k])
        pid_term = 1'b1;
    end
  end

  assign preset_bus.wr_en = preset_wr_i;
  assign preset_bus.wr_addr = preset_addr_i;
  assign preset_bus.wr_data = preset_data_i;
  assign preset_bus.rd_addr = ms_idx;

  preset_table #(.DEPTH(N_PRESET)) u_presets (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .bus(preset_bus.mem)
  );

  // ----------------------------------------------------------------
  // Source values and selection
  // ----------------------------------------------------------------
  logic [1:0][12:0] ai_frac;
  logic [12:0] pulse_frac;
  logic [3:0] bind_digit;
  logic bound;
  logic [3:0] sel_code;
  logic signed [13:0] sel_frac;

  genvar ga;
  generate
    for (ga = 0; ga < 2; ga++)
    begin : g_analog
      logic [11:0] raw;
      logic [2:0] cs;
      assign raw = (ga == 0) ? analog_input_first_i : analog_input_second_i;
      assign cs = (analog_curve_select_i[ga] > 3'h4) ? 3'h4 : analog_curve_select_i[ga];
      assign ai_frac[ga] = map_curve({4'h0, raw}, {4'h0, curve_in_lo_i[cs]},
        {4'h0, curve_in_hi_i[cs]}, curve_set_lo_i[cs], curve_set_hi_i[cs]);
    end
  endgenerate

  assign pulse_frac = map_curve(st.pulse_rate, pulse_curve_first_param_i,
    pulse_curve_in_hi_i, pulse_curve_set_lo_i, pulse_curve_set_hi_i);

  always_comb
  begin
    case (command_source_select_i)
      CMD_PANEL: bind_digit = source_binding_select_i[3:0];
      CMD_TERMINAL: bind_digit = source_binding_select_i[7:4];
      CMD_COMM: bind_digit = source_binding_select_i[11:8];
      default: bind_digit = 4'h0;
    endcase
  end

  assign bound = bind_digit != 4'h0;
  // A bound channel overrides both main and auxiliary sources
  assign sel_code = bound ? bind_digit : (use_aux_i ? aux_source_select_i : main_source_select_i);

  always_comb
  begin
    case (sel_code)
      SRC_DIGITAL, SRC_DIGITAL_RET: sel_frac = signed'({1'b0, digital_frac_i});
      SRC_ANALOG_FIRST: sel_frac = signed'({1'b0, ai_frac[0]});
      SRC_ANALOG_SECOND: sel_frac = signed'({1'b0, ai_frac[1]});
      SRC_PULSE: sel_frac = signed'({1'b0, pulse_frac});
      SRC_MULTI: sel_frac = signed'({1'b0, preset_bus.rd_data});
      SRC_PLC: sel_frac = signed'({1'b0, plc_frac_i});
      SRC_PID: sel_frac = signed'({1'b0, st.pid_out});
      SRC_COMM: sel_frac = comm_frac_i;
      default: sel_frac = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic neg;
    logic [12:0] mag;
    logic running;
    logic want_rev;
    logic inhibit;
    logic [CNT_W-1:0] inc;
    int err;
    int abs_err;
    int acc;
    int outv;
    neg = 1'b0;
    mag = '0;
    running = 1'b0;
    want_rev = 1'b0;
    inhibit = 1'b0;
    inc = '0;
    err = 0;
    abs_err = 0;
    acc = 0;
    outv = 0;
    next_st = st;
    next_st.di_meta = di_i;
    next_st.di_sync = st.di_meta;
    next_st.di_prev = st.di_sync;

    // Pulse rate over a fixed gate window
    if (st.gate_cnt >= GATE_W'(GATE_CYCLES - 1))
    begin
      next_st.gate_cnt = '0;
      next_st.pulse_rate = st.pulse_acc;
      next_st.pulse_acc = {15'h0000, di_rise[FAST_DI]};
    end
    else
    begin
      next_st.gate_cnt = st.gate_cnt + 1'b1;
      if (di_rise[FAST_DI] && st.pulse_acc != 16'hffff)
        next_st.pulse_acc = st.pulse_acc + 1'b1;
    end

    // Two PI units, chosen by error size or by a terminal
    err = int'(pid_setpoint_i) - int'(pid_feedback_i);
    abs_err = (err < 0) ? -err : err;
    next_st.pid_unit = pid_auto_switch_i ? (abs_err > int'(pid_switch_error_i)) : pid_term;
    if (sel_code != SRC_PID)
    begin
      next_st.pid_integ = '0;
      next_st.pid_out = '0;
    end
    else
    begin
      acc = int'(st.pid_integ) + err * int'(pid_ki_i[st.pid_unit]);
      if (acc > PID_INT_MAX)
        acc = PID_INT_MAX;
      if (acc < -PID_INT_MAX)
        acc = -PID_INT_MAX;
      next_st.pid_integ = 24'(acc);
      outv = (err * int'(pid_kp_i[st.pid_unit]) + acc) >>> PID_SHIFT;
      if (outv < 0)
        outv = 0;
      if (outv > int'(FRAC_FULL))
        outv = int'(FRAC_FULL);
      next_st.pid_out = 13'(outv);
    end

    // Direction and frequency
    neg = sel_frac < 0;
    mag = neg ? 13'(-sel_frac) : 13'(sel_frac);
    if (mag > FRAC_FULL)
      mag = FRAC_FULL;
    running = run_fwd_i ^ run_rev_i;
    want_rev = run_rev_i ^ neg;
    inhibit = reverse_inhibit_i && (run_rev_i || neg);
    next_st.drive_en = running && !inhibit;
    next_st.freq = next_st.drive_en ? scale_freq(mag, max_frequency_i) : 16'h0000;
    next_st.motor_rev = (want_rev && !inhibit) ^ direction_invert_i;

    // Length count and threshold
    if (len_rst)
    begin
      next_st.length_pulses = '0;
      next_st.actual_length = '0;
      next_st.length_reached = 1'b0;
    end
    else
    begin
      if (len_edge && st.length_pulses != 32'hffffffff)
        next_st.length_pulses = st.length_pulses + 1'b1;
      next_st.actual_length = (pulses_per_meter_i == 16'h0000) ? 32'h00000000 :
        st.length_pulses / {16'h0000, pulses_per_meter_i};
      next_st.length_reached = next_st.actual_length > set_length_i;
    end

    // Event counter runs whatever the drive state
    if (count_clear_i)
    begin
      next_st.event_count = '0;
      next_st.cnt_state = CNT_RUN;
    end
    else if (count_load_i)
    begin
      next_st.event_count = count_load_value_i;
      next_st.cnt_state = (count_load_value_i >= set_count_i) ? CNT_DONE : CNT_RUN;
    end
    else
    begin
      case (st.cnt_state)
        CNT_RUN:
        begin
          inc = st.event_count + CNT_W'(count_edge);
          next_st.event_count = inc;
          if (inc >= set_count_i)
            next_st.cnt_state = CNT_DONE;
        end
        CNT_DONE: next_st.event_count = st.event_count;
        default: next_st.cnt_state = CNT_RUN;
      endcase
    end
    next_st.set_reached = next_st.cnt_state == CNT_DONE;
    next_st.desig_reached = next_st.event_count >= designated_count_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= RESET_ST;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign target_freq_o = st.freq;
  assign drive_enable_o = st.drive_en;
  assign motor_reverse_o = st.motor_rev;
  assign pid_unit_o = st.pid_unit;
  assign actual_length_o = st.actual_length;
  assign length_reached_o = st.length_reached;
  assign count_value_o = st.event_count;
  assign set_count_reached_o = st.set_reached;
  assign designated_count_reached_o = st.desig_reached;

  genvar gd;
  generate
    for (gd = 0; gd < N_DO; gd++)
    begin : g_do
      assign do_o[gd] = (do_function_i[gd] == DO_SET_COUNT && st.set_reached) ||
        (do_function_i[gd] == DO_DESIG_COUNT && st.desig_reached) ||
        (do_function_i[gd] == DO_LEN_REACHED && st.length_reached);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  logic ms3_used;
  always_comb
  begin
    ms3_used = 1'b0;
    for (int k = 0; k < N_DI; k++)
      if (di_function_i[k] == FN_MS3)
        ms3_used = 1'b1;
  end

  sequence s_done_held;
    (set_count_reached_o && !count_clear_i && !count_load_i) ##1 (!count_clear_i && !count_load_i);
  endsequence

  a_bind_override: assert property ((bind_digit == SRC_DIGITAL_RET && run_fwd_i && !run_rev_i
    && digital_frac_i <= FRAC_FULL) |=> target_freq_o ==
    scale_freq($past(digital_frac_i), $past(max_frequency_i)))
    else $error("bound channel not used");
  a_multi_speed: assert property ((sel_code == SRC_MULTI && run_fwd_i && !run_rev_i
    && preset_bus.rd_data <= FRAC_FULL) |=> target_freq_o ==
    scale_freq($past(preset_bus.rd_data), $past(max_frequency_i)))
    else $error("preset frequency wrong");
  a_unused_bit: assert property (!ms3_used |-> !ms_idx[3])
    else $error("unassigned index bit set");
  a_comm_reverse: assert property ((sel_code == SRC_COMM && comm_frac_i < 0 && run_fwd_i
    && !run_rev_i && !reverse_inhibit_i && !direction_invert_i) |=> motor_reverse_o && drive_enable_o)
    else $error("negative reference not reversed");
  a_reverse_block: assert property ((reverse_inhibit_i && (run_rev_i || sel_frac < 0))
    |=> target_freq_o == 16'h0000 && !drive_enable_o)
    else $error("inhibited reverse still driven");
  a_dir_invert: assert property ((run_fwd_i && !run_rev_i && sel_frac >= 0)
    |=> motor_reverse_o == $past(direction_invert_i))
    else $error("direction invert not applied");
  a_length_step: assert property ((len_edge && !len_rst && st.length_pulses != 32'hffffffff)
    |=> st.length_pulses == $past(st.length_pulses) + 32'h1)
    else $error("length pulse lost");
  a_length_flag: assert property (($stable(set_length_i) && !$past(len_rst))
    |-> length_reached_o == (actual_length_o > set_length_i))
    else $error("length flag wrong");
  a_length_clear: assert property (len_rst |=> st.length_pulses == 32'h0 && !length_reached_o)
    else $error("length clear failed");
  a_count_frozen: assert property (s_done_held |-> $stable(count_value_o) && set_count_reached_o)
    else $error("counter moved after set count");
  a_count_desig: assert property ((count_edge && st.cnt_state == CNT_RUN && !count_clear_i
    && !count_load_i && count_value_o + CNT_W'(1) == designated_count_i)
    |=> designated_count_reached_o)
    else $error("designated count missed");
endmodule
`default_nettype wire

/* File: hdl/preset_if.sv */
// Interface: preset table write and read path
`default_nettype none
interface preset_if;
  import freq_ref_pkg::*;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [12:0] wr_data;
  logic [3:0] rd_addr;
  logic [12:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: hdl/preset_table.sv */
// Module: multi-speed preset table with registered read data
`default_nettype none
module preset_table
  import freq_ref_pkg::*;
#(
  parameter int DEPTH = N_PRESET
)(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Table access
  preset_if.mem bus
);
  logic [12:0] table_mem [DEPTH];

  always_ff @(posedge ref_clk_i)
  begin
    if (bus.wr_en)
    begin
      table_mem[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus.rd_data <= '0;
    end
    else
    begin
      bus.rd_data <= table_mem[bus.rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: test/terminal_model.sv */
// Partner model: input terminals that hold levels or emit pulses
`default_nettype none
module terminal_model
  import freq_ref_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Requests from the bench
  input wire logic [N_DI-1:0] level_i,
  input wire logic [N_DI-1:0] pulse_i,
  // Terminal pins
  output logic [N_DI-1:0] di_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [N_DI-1:0][2:0] width = '0;
  // A pulse stays high four cycles so the input synchroniser sees it
  always_ff @(posedge ref_clk_i)
  begin
    for (int k = 0; k < N_DI; k++)
    begin
      width[k] <= pulse_i[k] ? 3'h4 : ((width[k] != 3'h0) ? width[k] - 3'h1 : 3'h0);
    end
  end
  always_comb
  begin
    for (int k = 0; k < N_DI; k++)
    begin
      di_o[k] = level_i[k] | (width[k] != 3'h0);
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Testbench: frequency reference selection, direction and counters
`default_nettype none
module testbench
  import freq_ref_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [N_DI-1:0] lvl = '0, pls = '0, di;
  logic [N_DI-1:0][5:0] di_fn = '0;
  logic [N_DO-1:0][5:0] do_fn = {DO_LEN_REACHED, DO_DESIG_COUNT, DO_SET_COUNT};
  logic [N_DO-1:0] do_o;
  logic fwd = 1'b0, rev = 1'b0, inv = 1'b0, inh = 1'b0, wr = 1'b0, clr = 1'b0, ld = 1'b0;
  logic [11:0] binding = '0, ai1 = '0;
  logic [1:0] cmd_src = CMD_PANEL;
  logic [3:0] main_src = SRC_DIGITAL, aux_src = SRC_COMM, waddr = '0;
  logic [12:0] dig = '0, wdata = '0, pset_hi = 13'h1000, pid_sp = '0, pid_fb = '0;
  logic [12:0] pid_err = 13'h0100;
  logic signed [13:0] comm = '0;
  logic [15:0] ppm = '0, freq, fmax = 16'h1000, pin_lo = '0, pin_hi = 16'h0002;
  logic [1:0][2:0] acurve = '0;
  logic [1:0][7:0] kp = '0;
  logic [4:0][11:0] cin_hi = '0;
  logic [4:0][12:0] cset_lo = '0, cset_hi = '0;
  logic [31:0] set_len = '0, set_cnt = '0, desig = '0, len, cnt, ld_val = 32'h1;
  logic en, mrev, len_hit, set_hit, des_hit, pid_unit, use_aux = 1'b0, pid_auto = 1'b0;
  int miscompares = 0, n_tests = 0;

  terminal_model u_term (.ref_clk_i(ref_clk_i), .level_i(lvl), .pulse_i(pls), .di_o(di));

  freq_reference_and_counters #(.GATE_CYCLES(50)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .di_i(di), .di_function_i(di_fn),
    .do_function_i(do_fn), .do_o(do_o), .run_fwd_i(fwd), .run_rev_i(rev),
    .command_source_select_i(cmd_src), .source_binding_select_i(binding),
    .main_source_select_i(main_src), .aux_source_select_i(aux_src), .use_aux_i(use_aux),
    .max_frequency_i(fmax), .direction_invert_i(inv), .reverse_inhibit_i(inh),
    .digital_frac_i(dig), .plc_frac_i(13'h0), .comm_frac_i(comm),
    .analog_input_first_i(ai1), .analog_input_second_i(12'h0),
    .analog_curve_select_i(acurve), .curve_in_lo_i('0), .curve_in_hi_i(cin_hi),
    .curve_set_lo_i(cset_lo), .curve_set_hi_i(cset_hi), .pulse_curve_first_param_i(pin_lo),
    .pulse_curve_in_hi_i(pin_hi), .pulse_curve_set_lo_i(13'h0), .pulse_curve_set_hi_i(pset_hi),
    .preset_wr_i(wr), .preset_addr_i(waddr), .preset_data_i(wdata),
    .pid_setpoint_i(pid_sp), .pid_feedback_i(pid_fb), .pid_kp_i(kp), .pid_ki_i('0),
    .pid_auto_switch_i(pid_auto), .pid_switch_error_i(pid_err),
    .pulses_per_meter_i(ppm), .set_length_i(set_len),
    .set_count_i(set_cnt), .designated_count_i(desig), .count_clear_i(clr),
    .count_load_i(ld), .count_load_value_i(ld_val),
    .target_freq_o(freq), .drive_enable_o(en), .motor_reverse_o(mrev), .pid_unit_o(pid_unit),
    .actual_length_o(len), .length_reached_o(len_hit), .count_value_o(cnt),
    .set_count_reached_o(set_hit), .designated_count_reached_o(des_hit));

  initial forever #10 ref_clk_i = ~ref_clk_i;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Direction is only meaningful while the drive is enabled
  task automatic chk_freq(input logic [15:0] f, input logic e, input logic r);
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk("target_freq", {16'h0, f}, {16'h0, freq});
    chk("drive_enable", {31'h0, e}, {31'h0, en});
    if (e)
      chk("motor_reverse", {31'h0, r}, {31'h0, mrev});
  endtask

  task automatic pulse(input logic [N_DI-1:0] mask, input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i);
      pls <= mask;
      @(posedge ref_clk_i);
      pls <= '0;
      repeat (8) @(posedge ref_clk_i);
    end
    #1;
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    main_src <= SRC_COMM;
    comm <= 14'sh0400;
    fwd <= 1'b1;
    chk_freq(16'h0400, 1'b1, 1'b0);
    @(posedge ref_clk_i);
    inv <= 1'b1;
    chk_freq(16'h0400, 1'b1, 1'b1);
    @(posedge ref_clk_i);
    inv <= 1'b0;
    comm <= -14'sh0400;
    chk_freq(16'h0400, 1'b1, 1'b1);
    @(posedge ref_clk_i);
    inh <= 1'b1;
    chk_freq(16'h0000, 1'b0, 1'b0);
    @(posedge ref_clk_i);
    comm <= 14'sh0400;
    fwd <= 1'b0;
    rev <= 1'b1;
    chk_freq(16'h0000, 1'b0, 1'b0);
    @(posedge ref_clk_i);
    inh <= 1'b0;
    chk_freq(16'h0400, 1'b1, 1'b1);
    @(posedge ref_clk_i);
    rev <= 1'b0;
    fwd <= 1'b1;
    dig <= 13'h0123;
    cmd_src <= CMD_TERMINAL;
    use_aux <= 1'b1;
    binding <= 12'h013;
    chk_freq(16'h0123, 1'b1, 1'b0);
    // Preset entry 2 selected by the bit-1 terminal alone
    @(posedge ref_clk_i);
    binding <= 12'h000;
    use_aux <= 1'b0;
    main_src <= SRC_MULTI;
    di_fn[1] <= FN_MS0 + 6'h01;
    lvl <= 5'h02;
    wr <= 1'b1;
    waddr <= 4'h2;
    wdata <= 13'h0a00;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    chk_freq(16'h0a00, 1'b1, 1'b0);
    // Length at two pulses per metre against one metre
    @(posedge ref_clk_i);
    lvl <= '0;
    di_fn[4] <= FN_LEN_IN;
    di_fn[0] <= FN_LEN_RST;
    ppm <= 16'h0002;
    set_len <= 32'h1;
    pulse(5'h10, 2);
    chk("actual_length", 32'h1, len);
    chk("length_reached", 32'h0, {30'h0, len_hit, do_o[2]});
    pulse(5'h10, 2);
    chk("actual_length", 32'h2, len);
    chk("length_reached", 32'h3, {30'h0, len_hit, do_o[2]});
    @(posedge ref_clk_i);
    lvl <= 5'h01;
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk("actual_length", 32'h0, len);
    chk("length_reached", 32'h0, {30'h0, len_hit, do_o[2]});
    // Event counter, counted while stopped
    @(posedge ref_clk_i);
    lvl <= '0;
    fwd <= 1'b0;
    di_fn[1] <= FN_COUNT_IN;
    set_cnt <= 32'h3;
    desig <= 32'h2;
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
    pulse(5'h02, 2);
    chk("count_value", 32'h2, cnt);
    chk("designated_flag", 32'h3, {30'h0, des_hit, do_o[1]});
    chk("set_flag", 32'h0, {30'h0, set_hit, do_o[0]});
    pulse(5'h02, 2);
    chk("count_value", 32'h3, cnt);
    chk("set_flag", 32'h3, {30'h0, set_hit, do_o[0]});
    @(posedge ref_clk_i);
    ld <= 1'b1;
    @(posedge ref_clk_i);
    ld <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("count_value", 32'h1, cnt);
    // Analog full scale through curve 2, then pulse rate, then PID
    @(posedge ref_clk_i);
    fwd <= 1'b1;
    main_src <= SRC_ANALOG_FIRST;
    fmax <= 16'h0c80;
    acurve[0] <= 3'h2;
    cin_hi[2] <= 12'h800;
    cset_hi[2] <= 13'h1000;
    ai1 <= 12'hfff;
    chk_freq(16'h0c80, 1'b1, 1'b0);
    @(posedge ref_clk_i);
    main_src <= SRC_PULSE;
    pulse(5'h10, 12);
    chk_freq(16'h0c80, 1'b1, 1'b0);
    @(posedge ref_clk_i);
    main_src <= SRC_PID;
    fmax <= 16'h1000;
    kp <= {8'h10, 8'h10};
    pid_sp <= 13'h0200;
    pid_auto <= 1'b1;
    chk_freq(16'h0020, 1'b1, 1'b0);
    chk("pid_unit", 32'h1, {31'h0, pid_unit});
    @(posedge ref_clk_i);
    pid_auto <= 1'b0;
    di_fn[2] <= FN_PID_SWITCH;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk("pid_unit", 32'h0, {31'h0, pid_unit});
    @(posedge ref_clk_i);
    lvl <= 5'h04;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk("pid_unit", 32'h1, {31'h0, pid_unit});
    end_of_test();
  end
endmodule
`default_nettype wire
